// ==== verilog/mscr_params.svh ====
// Offsets, bit positions, reset values and codes of the mode and system control registers
`ifndef MSCR_PARAMS_SVH
`define MSCR_PARAMS_SVH

// Register byte offsets
`define MSCR_SYSCTL_OFFSET   8'h00
`define MSCR_MODE_OFFSET     8'h04

// System control field positions
`define MSCR_BIT_MAC_SAT     13
`define MSCR_BIT_FETCH       11
`define MSCR_BIT_EXT_BUS     9
`define MSCR_BIT_RAM_EN      8
`define MSCR_BIT_XFER_MODE   1

// System control reset values of the writable fields
`define MSCR_RST_MAC_SAT     1'h0
`define MSCR_RST_FETCH       1'h0
`define MSCR_RST_EXT_SINGLE  1'h0
`define MSCR_RST_RAM_EN      1'h1
`define MSCR_RST_XFER_MODE   1'h1

// Reserved bits that always read as one (15, 14, 12, 0)
`define MSCR_SYSCTL_ONES     16'hd001

// Mode status fixed pattern and mode select positions
`define MSCR_MODE_FIXED      16'h5050
`define MSCR_MODE_SEL_HI     8
`define MSCR_MODE_SEL_LO     0

// Mode pin codes and their reported codes
`define MSCR_PINS_MODE4      3'h4
`define MSCR_PINS_MODE5      3'h5
`define MSCR_SEL_MODE4       3'h2
`define MSCR_SEL_MODE5       3'h1
`define MSCR_SEL_OTHER       3'h0

// AXI responses
`define MSCR_RESP_OKAY       2'h0
`define MSCR_RESP_SLVERR     2'h2

`endif

// ==== verilog/mscr_pkg.sv ====
// Types and decode functions of the mode and system control registers
`include "mscr_params.svh"

package mscr_pkg;

  // Writable system control fields as seen by the core
  typedef struct packed {
    logic mac_saturate_sel;
    logic fetch_width_sel;
    logic ext_bus_enable;
    logic internal_ram_enable;
    logic transfer_ctrl_addr_mode;
  } mscr_sysctl_t;

  // Mode pins to mode select code
  function automatic logic [2:0] mscr_decode_mode(input logic [2:0] pins);
    case (pins)
      `MSCR_PINS_MODE4: mscr_decode_mode = `MSCR_SEL_MODE4;
      `MSCR_PINS_MODE5: mscr_decode_mode = `MSCR_SEL_MODE5;
      default:          mscr_decode_mode = `MSCR_SEL_OTHER;
    endcase
  endfunction : mscr_decode_mode

  // Mode pins select an external extended mode
  function automatic logic mscr_is_ext(input logic [2:0] pins);
    mscr_is_ext = (pins == `MSCR_PINS_MODE4) || (pins == `MSCR_PINS_MODE5);
  endfunction : mscr_is_ext

endpackage : mscr_pkg

// ==== verilog/mscr_mode_latch.sv ====
// Mode pin latch and startup mode capture
`include "mscr_params.svh"

module mscr_mode_latch (
  input  logic       aclk,
  input  logic       aresetn,
  input  logic [2:0] mode_pins,
  input  logic       capture,
  output logic [2:0] mode_select,
  output logic       ext_mode
);
  import mscr_pkg::*;

  logic [2:0] sel_reg;
  logic [2:0] sel_next;
  logic [2:0] sel_new;
  logic       ext_reg;
  logic       ext_next;

  assign sel_new = mscr_decode_mode(mode_pins);

  // Per-bit latch: transparent in reset, loads on a status read
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_bit
      always_comb begin
        sel_next[i] = sel_reg[i];
        if (!aresetn || capture) begin
          sel_next[i] = sel_new[i];
        end
      end
    end
  endgenerate

  // Startup mode follows the pins only while reset is held
  always_comb begin
    ext_next = ext_reg;
    if (!aresetn) begin
      ext_next = mscr_is_ext(mode_pins);
    end
  end

  // State registers
  always_ff @(posedge aclk) begin
    sel_reg <= sel_next;
    ext_reg <= ext_next;
  end

  assign mode_select = sel_reg;
  assign ext_mode    = ext_reg;

endmodule : mscr_mode_latch

// ==== verilog/mscr_regs.sv ====
// AXI4-Lite register bank for mode status and system control
`include "mscr_params.svh"

module mscr_regs #(
  parameter int ADDR_WIDTH = 8
) (
  input  logic                  aclk,
  input  logic                  aresetn,
  input  logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  logic                  s_axi_awvalid,
  output logic                  s_axi_awready,
  input  logic [31:0]           s_axi_wdata,
  input  logic [3:0]            s_axi_wstrb,
  input  logic                  s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  logic                  s_axi_bready,
  input  logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  logic                  s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  logic                  s_axi_rready,
  input  logic [2:0]            mode_pins,
  output mscr_pkg::mscr_sysctl_t sysctl,
  output logic [2:0]            mode_select
);
  import mscr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check

  generate
    if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_addr
      $error("mscr_regs: ADDR_WIDTH must lie in 8..32");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam logic [ADDR_WIDTH-1:0] SYSCTL_ADDR = ADDR_WIDTH'(`MSCR_SYSCTL_OFFSET);
  localparam logic [ADDR_WIDTH-1:0] MODE_ADDR   = ADDR_WIDTH'(`MSCR_MODE_OFFSET);

  logic                  awready_reg, awready_next;
  logic                  wready_reg,  wready_next;
  logic                  aw_have_reg, aw_have_next;
  logic                  w_have_reg,  w_have_next;
  logic [ADDR_WIDTH-1:0] awaddr_reg,  awaddr_next;
  logic [15:0]           wdata_reg,   wdata_next;
  logic [1:0]            wstrb_reg,   wstrb_next;
  logic                  bvalid_reg,  bvalid_next;
  logic [1:0]            bresp_reg,   bresp_next;
  logic                  arready_reg, arready_next;
  logic                  rvalid_reg,  rvalid_next;
  logic [31:0]           rdata_reg,   rdata_next;
  logic [1:0]            rresp_reg,   rresp_next;
  mscr_sysctl_t          sysctl_reg,  sysctl_next;
  mscr_sysctl_t          sysctl_rst;
  logic                  capture;
  logic                  ext_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Read views

  // System control word with fixed reserved bits
  function automatic logic [15:0] sysctl_word(input mscr_sysctl_t s);
    logic [15:0] w;
    w = `MSCR_SYSCTL_ONES;
    w[`MSCR_BIT_MAC_SAT]   = s.mac_saturate_sel;
    w[`MSCR_BIT_FETCH]     = s.fetch_width_sel;
    w[`MSCR_BIT_EXT_BUS]   = s.ext_bus_enable;
    w[`MSCR_BIT_RAM_EN]    = s.internal_ram_enable;
    w[`MSCR_BIT_XFER_MODE] = s.transfer_ctrl_addr_mode;
    sysctl_word = w;
  endfunction : sysctl_word

  // Mode status word with fixed pattern and two copies of the code
  function automatic logic [15:0] mode_word(input logic [2:0] sel);
    logic [15:0] w;
    w = `MSCR_MODE_FIXED;
    w[`MSCR_MODE_SEL_HI +: 3] = sel;
    w[`MSCR_MODE_SEL_LO +: 3] = sel;
    mode_word = w;
  endfunction : mode_word

  ////////////////////////////////////////////////////////////////////////////
  // Mode pin latch

  mscr_mode_latch u_mode_latch (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .mode_pins   (mode_pins),
    .capture     (capture),
    .mode_select (mode_select),
    .ext_mode    (ext_mode)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset image of the control fields

  always_comb begin
    sysctl_rst.mac_saturate_sel        = `MSCR_RST_MAC_SAT;
    sysctl_rst.fetch_width_sel         = `MSCR_RST_FETCH;
    sysctl_rst.ext_bus_enable          = mscr_is_ext(mode_pins) | `MSCR_RST_EXT_SINGLE;
    sysctl_rst.internal_ram_enable     = `MSCR_RST_RAM_EN;
    sysctl_rst.transfer_ctrl_addr_mode = `MSCR_RST_XFER_MODE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel and control fields

  // Collect address and data in either order, then commit and respond
  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    sysctl_next  = sysctl_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_have_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_have_next = 1'b1;
      wdata_next  = s_axi_wdata[15:0];
      wstrb_next  = s_axi_wstrb[1:0];
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = `MSCR_RESP_SLVERR;
      if (awaddr_reg == SYSCTL_ADDR) begin
        bresp_next = `MSCR_RESP_OKAY;
        // Low lane holds the transfer mode bit
        if (wstrb_reg[0]) begin
          sysctl_next.transfer_ctrl_addr_mode = wdata_reg[`MSCR_BIT_XFER_MODE];
        end
        // High lane holds saturation, fetch, external bus and RAM enable
        if (wstrb_reg[1]) begin
          sysctl_next.mac_saturate_sel    = wdata_reg[`MSCR_BIT_MAC_SAT];
          sysctl_next.fetch_width_sel     = wdata_reg[`MSCR_BIT_FETCH];
          sysctl_next.ext_bus_enable      = wdata_reg[`MSCR_BIT_EXT_BUS];
          sysctl_next.internal_ram_enable = wdata_reg[`MSCR_BIT_RAM_EN];
        end
      end else if (awaddr_reg == MODE_ADDR) begin
        bresp_next = `MSCR_RESP_OKAY; // Read-only: write dropped
      end
    end
    // External extended modes pin the external bus enable high
    if (ext_mode) begin
      sysctl_next.ext_bus_enable = 1'b1;
    end
    awready_next = !aw_have_next && !bvalid_next;
    wready_next  = !w_have_next && !bvalid_next;
  end

  // Write side registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 16'h0000;
      wstrb_reg   <= 2'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `MSCR_RESP_OKAY;
      sysctl_reg  <= sysctl_rst;
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      sysctl_reg  <= sysctl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  // Answer one read at a time; a status read also reloads the latch
  always_comb begin
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    capture      = 1'b0;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = `MSCR_RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      if (s_axi_araddr == SYSCTL_ADDR) begin
        rdata_next[15:0] = sysctl_word(sysctl_reg);
      end else if (s_axi_araddr == MODE_ADDR) begin
        capture          = 1'b1;
        rdata_next[15:0] = mode_word(mscr_decode_mode(mode_pins));
      end else begin
        rresp_next = `MSCR_RESP_SLVERR;
      end
    end
    arready_next = !rvalid_next;
  end

  // Read side registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `MSCR_RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign sysctl        = sysctl_reg;

endmodule : mscr_regs

// ==== sim/mscr_regs_checker.sv ====
// Concurrent checks of the mode and system control register bank
`include "mscr_params.svh"

module mscr_regs_checker #(
  parameter int ADDR_WIDTH = 8
) (
  input logic                   aclk,
  input logic                   aresetn,
  input logic [1:0]             s_axi_bresp,
  input logic                   s_axi_bvalid,
  input logic                   s_axi_bready,
  input logic [ADDR_WIDTH-1:0]  s_axi_araddr,
  input logic                   s_axi_arvalid,
  input logic                   s_axi_arready,
  input logic [31:0]            s_axi_rdata,
  input logic [1:0]             s_axi_rresp,
  input logic                   s_axi_rvalid,
  input logic [2:0]             mode_pins,
  input mscr_pkg::mscr_sysctl_t sysctl,
  input logic [2:0]             mode_select
);
  timeunit 1ns;
  timeprecision 1ns;
  import mscr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [ADDR_WIDTH-1:0] rd_addr_reg;
  logic [4:0]            sys_reg;
  logic                  boot_ext_reg;
  logic [2:0]            pin_code;
  logic                  mode_rd;

  // Expected mode code and mode status read request
  assign pin_code = (mode_pins == 3'h4) ? 3'h2 : (mode_pins == 3'h5) ? 3'h1 : 3'h0;
  assign mode_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == `MSCR_MODE_OFFSET;

  // Startup mode, last read address and last control value
  always_ff @(posedge aclk) begin
    if (!aresetn) boot_ext_reg <= (pin_code != 3'h0);
    if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
    sys_reg <= sysctl;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // First cycle of a read answer, control or unmapped
  sequence s_ctl_ans;
    $rose(s_axi_rvalid) && rd_addr_reg == `MSCR_SYSCTL_OFFSET;
  endsequence
  sequence s_bad_ans;
    $rose(s_axi_rvalid) && rd_addr_reg != `MSCR_SYSCTL_OFFSET && rd_addr_reg != `MSCR_MODE_OFFSET;
  endsequence

  // Mode status request, then its answer one edge later
  sequence s_mode_req;
    mode_rd;
  endsequence
  sequence s_mode_ans;
    s_axi_rvalid && s_axi_rdata[10:8] == $past(pin_code) && mode_select == $past(pin_code);
  endsequence

  AST_RSV_ONES: assert property (
    s_ctl_ans |-> s_axi_rdata[15:14] == 2'h3 && s_axi_rdata[12])
    else $error("reserved control bits not one");
  AST_CTL_FIELDS: assert property (
    s_ctl_ans |-> s_axi_rdata[13:0] ==
    {sys_reg[4], 1'b1, sys_reg[3], 1'b0, sys_reg[2:1], 6'h00, sys_reg[0], 1'b1})
    else $error("control read does not match fields");
  AST_EXT_HELD: assert property (boot_ext_reg |-> sysctl.ext_bus_enable)
    else $error("external bus enable not held at one");
  AST_RST_VAL: assert property (
    $rose(aresetn) |-> sysctl == {2'h0, boot_ext_reg, 2'h3})
    else $error("control reset value wrong");
  AST_MODE_READ: assert property (s_mode_req |=> s_mode_ans)
    else $error("mode code not latched on read");
  AST_MODE_HOLD: assert property (!mode_rd |=> $stable(mode_select))
    else $error("mode code changed without read");
  AST_BAD_ADDR: assert property (
    s_bad_ans |-> s_axi_rresp == `MSCR_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule : mscr_regs_checker

bind mscr_regs mscr_regs_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (
  .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .mode_pins, .sysctl, .mode_select
);

// ==== sim/mscr_regs_bench.sv ====
// Self-checking bench of the mode and system control register bank
module mscr_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mscr_pkg::*;

  logic         aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic         s_axi_rready;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [2:0]   mode_pins, mode_select;
  mscr_sysctl_t sysctl;
  int           errors, n_checks, seed, mac, fetch, ext, ram, xfer, boot;

  mscr_regs #(.ADDR_WIDTH(8)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .mode_pins, .sysctl, .mode_select
  );

  // Free running clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic stall;
    errors++;
    $display("[ERR] handshake expected answer seen timeout");
    final_report();
  endtask : stall

  ////////////////////////////////////////////////////////////////////////////
  // Bus write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 64) stall();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 64) stall();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // Control register against the model
  task automatic chk_ctl;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0]  r;
    rd(8'h00, d, r);
    e = 32'hd001 | mac << 13 | fetch << 11 | ext << 9;
    e = e | ram << 8 | xfer << 1;
    chk("ctl_rdata", e, d);
    chk("ctl_rresp", 32'h0, {30'h0, r});
    chk("sysctl", {27'h0, mac[0], fetch[0], ext[0], ram[0], xfer[0]}, {27'h0, sysctl});
  endtask : chk_ctl

  // Mode status against the current pins
  task automatic chk_mode;
    logic [31:0] d;
    logic [1:0]  r;
    logic [2:0]  c;
    rd(8'h04, d, r);
    c = (mode_pins == 3'h4) ? 3'h2 : (mode_pins == 3'h5) ? 3'h1 : 3'h0;
    chk("mode_rdata", 32'h5050 | c << 8 | c, d);
    chk("mode_select", {29'h0, c}, {29'h0, mode_select});
  endtask : chk_mode

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: one reset per startup pin setting in pins
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [3:0]  s;
    logic [2:0]  pins [4];
    pins = '{3'h4, 3'h5, 3'h0, 3'h6};
    seed = 32'hc063;
    errors = 0;
    n_checks = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= 52'h0;
    aresetn <= 1'b0;
    mode_pins <= 3'h0;
    foreach (pins[t]) begin
      @(posedge aclk);
      aresetn <= 1'b0;
      mode_pins <= pins[t];
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      boot = (pins[t] == 3'h4 || pins[t] == 3'h5);
      mac = 0;
      fetch = 0;
      ext = boot;
      ram = 1;
      xfer = 1;
      chk_ctl();
      chk_mode();
      repeat (6) begin
        d = $random(seed) & 32'h2b02 | 32'hd001;
        s = 4'($random(seed));
        wr(8'h00, d, s, r);
        chk("ctl_bresp", 32'h0, {30'h0, r});
        if (s[1]) begin
          mac = d[13];
          fetch = d[11];
          ram = d[8];
          if (!boot) ext = d[9];
        end
        if (s[0]) xfer = d[1];
        chk_ctl();
        mode_pins <= 3'($random(seed));
        chk_mode();
      end
      wr(8'h04, 32'hffffffff, 4'hf, r);
      chk("mode_bresp", 32'h0, {30'h0, r});
      wr(8'h0c, 32'h0, 4'hf, r);
      chk("bad_bresp", 32'h2, {30'h0, r});
      rd(8'h08, d, r);
      chk("bad_rresp", 32'h2, {30'h0, r});
      chk("bad_rdata", 32'h0, d);
      chk_ctl();
      $display("test with startup pins %h done", pins[t]);
    end
    final_report();
  end
endmodule : mscr_regs_bench
